// [psl_strap_gate.sv]
// Power-on strap latch, dual-purpose pin control and memory clock gate
//
// The AXI4-Lite register port and the register addresses were decided locally.
`include "psl_cfg.svh"

module psl_strap_gate
  import psl_pkg::*;
#(
  parameter int SEL_CYCLES = `PSL_SEL_CYCLES
) (
  // Clock and power-on reset
  input wire logic CLK,
  input wire logic SRST,
  // Power control pins
  input wire logic PWR_GOOD,
  input wire logic POWER_DOWN_N,
  // Memory clock fan-out
  input wire logic MEMCLK_FANOUT_IN,
  output logic [`PSL_MEMCLK_N-1:0] MEMCLK_FANOUT_OUT,
  // Clock sources from the synthesiser
  input wire logic PROC_SRC,
  input wire logic PROC_SS_SRC,
  input wire logic BUS_SRC,
  input wire logic BUS_SS_SRC,
  input wire logic USB_SRC,
  input wire logic SIO_SRC,
  input wire logic REF_SRC,
  // Dual-purpose strap pins
  input wire logic [`PSL_STRAP_N-1:0] STRAP_PIN_I,
  output logic [`PSL_STRAP_N-1:0] STRAP_PIN_O,
  output logic [`PSL_STRAP_N-1:0] STRAP_PIN_OE_N,
  // Shared reference pin
  input wire logic REF_CLK_OUT0_I,
  output logic REF_CLK_OUT0_O,
  output logic REF_CLK_OUT0_OE_N,
  // Processor clocks
  output logic PROC_CLK_TRUE,
  output logic PROC_CLK_COMP_O,
  output logic PROC_CLK_COMP_OE_N,
  output logic CHIPSET_PROC_CLK_O,
  output logic CHIPSET_PROC_CLK_OE_N,
  // Dedicated bus clocks
  output logic [`PSL_BUSCLK_N-1:0] BUS_CLK_OUT,
  // Latched configuration
  output logic [3:0] FREQ_SELECT_STRAPS,
  output logic FUNCTION_STRAP,
  output logic STRAPS_VALID,
  output logic SPREAD_ACTIVE,
  // AXI4-Lite write address
  input wire logic [3:0] AWADDR,
  input wire logic AWVALID,
  output logic AWREADY,
  // AXI4-Lite write data
  input wire logic [31:0] WDATA,
  input wire logic [3:0] WSTRB,
  input wire logic WVALID,
  output logic WREADY,
  // AXI4-Lite write response
  output logic [1:0] BRESP,
  output logic BVALID,
  input wire logic BREADY,
  // AXI4-Lite read address
  input wire logic [3:0] ARADDR,
  input wire logic ARVALID,
  output logic ARREADY,
  // AXI4-Lite read data
  output logic [31:0] RDATA,
  output logic [1:0] RRESP,
  output logic RVALID,
  input wire logic RREADY
);

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers

  logic pg_s, pdn_s, mem_s, stop_n_s;
  logic [`PSL_STRAP_N-1:0] strap_s;

  psl_sync2 #(.W(4)) u_sync_ctl (
    .CLK(CLK),
    .SRST(SRST),
    .D({PWR_GOOD, POWER_DOWN_N, MEMCLK_FANOUT_IN, REF_CLK_OUT0_I}),
    .Q({pg_s, pdn_s, mem_s, stop_n_s})
  );

  psl_sync2 #(.W(`PSL_STRAP_N)) u_sync_strap (
    .CLK(CLK),
    .SRST(SRST),
    .D(STRAP_PIN_I),
    .Q(strap_s)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Selection sequence

  localparam logic [`PSL_TMR_W-1:0] SEL_LAST =
    `PSL_TMR_W'(SEL_CYCLES - 1);

  psl_state_t state_q;
  logic [`PSL_TMR_W-1:0] tmr_q;
  logic pg_prev_q;
  logic pg_rise;
  logic sel_last;
  logic [`PSL_STRAP_N-1:0] strap_q;
  logic valid_q;
  logic drive_q;

  assign pg_rise = pg_s & ~pg_prev_q;
  assign sel_last = (state_q == ST_SELECT) && (tmr_q == SEL_LAST);

  always_ff @(posedge CLK) begin
    if (SRST) begin
      pg_prev_q <= 1'b0;
    end else begin
      pg_prev_q <= pg_s;
    end
  end

  // Timer runs only after the power-good event; later events are ignored
  always_ff @(posedge CLK) begin
    if (SRST) begin
      state_q <= ST_WAIT_PG;
    end else begin
      case (state_q)
        ST_WAIT_PG: begin
          if (pg_rise) begin // [R8]
            state_q <= ST_SELECT;
          end
        end
        ST_SELECT: begin
          if (sel_last) begin // [R4]
            state_q <= ST_RUN;
          end
        end
        ST_RUN: begin
          state_q <= ST_RUN;
        end
        default: begin
          state_q <= ST_WAIT_PG;
        end
      endcase
    end
  end

  always_ff @(posedge CLK) begin
    if (SRST) begin
      tmr_q <= '0;
    end else if (state_q == ST_SELECT && !sel_last) begin
      tmr_q <= tmr_q + `PSL_TMR_W'(1);
    end
  end

  // Straps are captured once; only the power-on reset clears them
  always_ff @(posedge CLK) begin
    if (SRST) begin
      strap_q <= '0;
      valid_q <= 1'b0;
    end else if (sel_last && !valid_q) begin
      strap_q <= strap_s; // [R3] [R6] [R7] [R9] [R15]
      valid_q <= 1'b1;
    end
  end

  // Drivers come on the cycle after the capture
  always_ff @(posedge CLK) begin
    if (SRST) begin
      drive_q <= 1'b0;
    end else begin
      drive_q <= valid_q; // [R15]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Spread selection

  logic ctrl_spread_q;
  psl_spread_t spread_sel;
  logic spread_on;

  always_comb begin
    spread_sel = SPREAD_OFF;
    if (strap_q[`PSL_PIN_FS3]) begin // [R12]
      case ({strap_q[`PSL_PIN_FS1], strap_q[`PSL_PIN_FS0]})
        2'b11: spread_sel = SPREAD_DOWN_050;
        2'b10: spread_sel = SPREAD_CTR_025;
        2'b01: spread_sel = SPREAD_CTR_050;
        default: spread_sel = SPREAD_OFF;
      endcase
    end
  end

  assign spread_on = valid_q && ctrl_spread_q && (spread_sel != SPREAD_OFF);

  ////////////////////////////////////////////////////////////////////////////
  // Clock outputs

  logic proc_src, bus_src, proc_stop, pdn;

  // Only processor and bus clocks take the modulated source
  assign proc_src = spread_on ? PROC_SS_SRC : PROC_SRC; // [R11]
  assign bus_src = spread_on ? BUS_SS_SRC : BUS_SRC; // [R11]
  assign pdn = ~pdn_s;
  assign proc_stop = ~strap_q[`PSL_PIN_MODE] & ~stop_n_s;

  always_ff @(posedge CLK) begin
    if (SRST) begin
      MEMCLK_FANOUT_OUT <= '0;
    end else begin
      MEMCLK_FANOUT_OUT <= {`PSL_MEMCLK_N{mem_s & pdn_s}}; // [R1] [R2]
    end
  end

  // No glitch guard on first enable: a short processor cycle may appear
  always_ff @(posedge CLK) begin
    if (SRST) begin
      PROC_CLK_TRUE <= 1'b0;
      PROC_CLK_COMP_O <= 1'b0;
      PROC_CLK_COMP_OE_N <= 1'b1;
      CHIPSET_PROC_CLK_O <= 1'b0;
      CHIPSET_PROC_CLK_OE_N <= 1'b1;
    end else if (!drive_q || pdn || proc_stop) begin
      PROC_CLK_TRUE <= 1'b0; // [R14]
      PROC_CLK_COMP_O <= 1'b0;
      PROC_CLK_COMP_OE_N <= 1'b1; // [R14]
      CHIPSET_PROC_CLK_O <= 1'b0;
      CHIPSET_PROC_CLK_OE_N <= ~drive_q;
    end else begin
      PROC_CLK_TRUE <= proc_src; // [R10]
      PROC_CLK_COMP_O <= ~proc_src;
      PROC_CLK_COMP_OE_N <= 1'b0;
      CHIPSET_PROC_CLK_O <= 1'b0;
      CHIPSET_PROC_CLK_OE_N <= proc_src;
    end
  end

  // Strap pins float until drive_q, then carry their clocks
  always_ff @(posedge CLK) begin
    if (SRST) begin
      STRAP_PIN_O <= '0;
      STRAP_PIN_OE_N <= '1;
    end else if (!drive_q) begin
      STRAP_PIN_O <= '0;
      STRAP_PIN_OE_N <= '1; // [R5] [R4]
    end else begin
      STRAP_PIN_OE_N <= '0; // [R7]
      STRAP_PIN_O <= pdn ? '0 :
        {bus_src, SIO_SRC, USB_SRC, bus_src, REF_SRC}; // [R14]
    end
  end

  always_ff @(posedge CLK) begin
    if (SRST) begin
      BUS_CLK_OUT <= '0;
    end else begin
      BUS_CLK_OUT <= {`PSL_BUSCLK_N{bus_src & drive_q & pdn_s}}; // [R14]
    end
  end

  // Shared pin is an input unless the function strap selects reference out
  always_ff @(posedge CLK) begin
    if (SRST) begin
      REF_CLK_OUT0_O <= 1'b0;
      REF_CLK_OUT0_OE_N <= 1'b1;
    end else if (drive_q && strap_q[`PSL_PIN_MODE]) begin // [R13]
      REF_CLK_OUT0_O <= REF_SRC & pdn_s; // [R14]
      REF_CLK_OUT0_OE_N <= 1'b0;
    end else begin
      REF_CLK_OUT0_O <= 1'b0;
      REF_CLK_OUT0_OE_N <= 1'b1; // [R13]
    end
  end

  always_ff @(posedge CLK) begin
    if (SRST) begin
      FREQ_SELECT_STRAPS <= '0;
      FUNCTION_STRAP <= 1'b0;
      STRAPS_VALID <= 1'b0;
      SPREAD_ACTIVE <= 1'b0;
    end else begin
      FREQ_SELECT_STRAPS <= strap_q[3:0]; // [R12]
      FUNCTION_STRAP <= strap_q[`PSL_PIN_MODE];
      STRAPS_VALID <= valid_q;
      SPREAD_ACTIVE <= spread_on;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite write path

  logic aw_full_q, w_full_q;
  logic [3:0] aw_addr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic b_done;

  assign b_done = BVALID && BREADY;

  always_ff @(posedge CLK) begin
    if (SRST) begin
      aw_full_q <= 1'b0;
      AWREADY <= 1'b1;
      aw_addr_q <= '0;
    end else if (b_done) begin
      aw_full_q <= 1'b0;
      AWREADY <= 1'b1;
    end else if (AWVALID && AWREADY) begin
      aw_full_q <= 1'b1;
      AWREADY <= 1'b0;
      aw_addr_q <= AWADDR;
    end
  end

  always_ff @(posedge CLK) begin
    if (SRST) begin
      w_full_q <= 1'b0;
      WREADY <= 1'b1;
      wdata_q <= '0;
      wstrb_q <= '0;
    end else if (b_done) begin
      w_full_q <= 1'b0;
      WREADY <= 1'b1;
    end else if (WVALID && WREADY) begin
      w_full_q <= 1'b1;
      WREADY <= 1'b0;
      wdata_q <= WDATA;
      wstrb_q <= WSTRB;
    end
  end

  // Only the control word is writable; status writes are dropped quietly
  always_ff @(posedge CLK) begin
    if (SRST) begin
      BVALID <= 1'b0;
      BRESP <= `PSL_RESP_OKAY;
      ctrl_spread_q <= `PSL_CTRL_RESET;
    end else if (b_done) begin
      BVALID <= 1'b0;
    end else if (aw_full_q && w_full_q && !BVALID) begin
      BVALID <= 1'b1;
      if (aw_addr_q[3:2] == `PSL_ADDR_CTRL >> 2) begin
        BRESP <= `PSL_RESP_OKAY;
        if (wstrb_q[0]) begin
          ctrl_spread_q <= wdata_q[`PSL_CTRL_SPREAD_ALLOW]; // [R11]
        end
      end else if (aw_addr_q[3:2] == `PSL_ADDR_STATUS >> 2) begin
        BRESP <= `PSL_RESP_OKAY;
      end else begin
        BRESP <= `PSL_RESP_SLVERR;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite read path

  logic [31:0] status_word;

  always_comb begin
    status_word = '0;
    status_word[`PSL_ST_FS_LSB +: 4] = strap_q[3:0];
    status_word[`PSL_ST_MODE] = strap_q[`PSL_PIN_MODE];
    status_word[`PSL_ST_VALID] = valid_q;
    status_word[`PSL_ST_SPREAD] = spread_on;
    status_word[`PSL_ST_PDN] = pdn;
    status_word[`PSL_ST_STATE_LSB +: 2] = state_q;
  end

  always_ff @(posedge CLK) begin
    if (SRST) begin
      ARREADY <= 1'b1;
      RVALID <= 1'b0;
      RDATA <= '0;
      RRESP <= `PSL_RESP_OKAY;
    end else if (RVALID && RREADY) begin
      RVALID <= 1'b0;
      ARREADY <= 1'b1;
    end else if (ARVALID && ARREADY) begin
      ARREADY <= 1'b0;
      RVALID <= 1'b1;
      RRESP <= `PSL_RESP_OKAY;
      if (ARADDR[3:2] == `PSL_ADDR_CTRL >> 2) begin
        RDATA <= {31'h0, ctrl_spread_q};
      end else if (ARADDR[3:2] == `PSL_ADDR_STATUS >> 2) begin
        RDATA <= status_word;
      end else begin
        RDATA <= '0;
        RRESP <= `PSL_RESP_SLVERR;
      end
    end
  end

endmodule

// [psl_cfg.svh]
// Constants for the power-on strap latch and memory clock gate
// How it works
// R1 - Each of the thirteen memory clock fan-out outputs copies the fan-out input.
// R2 - All memory clock fan-out outputs go low while power_down_n is low.
// R3 - At power-up the five dual-purpose pins are read as strap inputs first.
// R4 - The first 2 ms after power-good is spent only on strap selection, no clocks; the memory clock fan-out outputs still copy their input.
// R5 - During selection all five dual-purpose pins are held in high impedance.
// R6 - A pin strapped to ground latches 0, a pin strapped to supply latches 1.
// R7 - When the 2 ms ends each pin level is latched, then the pins become clocks.
// R8 - The selection timer starts only on the internal power-good event.
// R9 - Latched straps never change until a full power-on reset.
// R10 - One truncated processor clock cycle is allowed when outputs first enable.
// R11 - Spreading applies only to processor and bus clocks and only when enabled.
// R12 - The four frequency straps pick processor and bus frequency and spreading.
// R13 - Function strap 0 makes the shared pin a stop input, 1 a reference output.
// R14 - In power-down the complement processor clock floats, all others go low.
// R15 - Straps are sampled on the last selection cycle, drivers enable the next.
`ifndef PSL_CFG_SVH
`define PSL_CFG_SVH

`define PSL_CLK_MHZ 10
`define PSL_SEL_TIME_US 2000
`define PSL_SEL_CYCLES (`PSL_SEL_TIME_US * `PSL_CLK_MHZ)
`define PSL_TMR_W 20

`define PSL_MEMCLK_N 13
`define PSL_STRAP_N 5
`define PSL_BUSCLK_N 4

`define PSL_PIN_FS0 0
`define PSL_PIN_FS1 1
`define PSL_PIN_FS2 2
`define PSL_PIN_FS3 3
`define PSL_PIN_MODE 4

`define PSL_ADDR_CTRL 4'h0
`define PSL_ADDR_STATUS 4'h4
`define PSL_CTRL_SPREAD_ALLOW 0
`define PSL_CTRL_RESET 1'b1
`define PSL_ST_FS_LSB 0
`define PSL_ST_MODE 4
`define PSL_ST_VALID 5
`define PSL_ST_SPREAD 6
`define PSL_ST_PDN 7
`define PSL_ST_STATE_LSB 8

`define PSL_RESP_OKAY 2'b00
`define PSL_RESP_SLVERR 2'b10

`endif

// [psl_pkg.sv]
// Types for the power-on strap latch and memory clock gate
package psl_pkg;

  typedef enum logic [1:0] {
    ST_WAIT_PG,
    ST_SELECT,
    ST_RUN
  } psl_state_t;

  typedef enum logic [1:0] {
    SPREAD_OFF,
    SPREAD_CTR_050,
    SPREAD_CTR_025,
    SPREAD_DOWN_050
  } psl_spread_t;

endpackage

// [psl_sync2.sv]
// Two-flop synchroniser for pin levels
module psl_sync2 #(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic CLK,
  input wire logic SRST,
  // Levels
  input wire logic [W-1:0] D,
  output logic [W-1:0] Q
);

  logic [W-1:0] meta_q;

  always_ff @(posedge CLK) begin
    if (SRST) begin
      meta_q <= '0;
      Q <= '0;
    end else begin
      meta_q <= D;
      Q <= meta_q;
    end
  end

endmodule

// [psl_strap_gate_chk.sv]
// Assertion checker for the strap latch and memory clock gate
`include "psl_cfg.svh"
module psl_strap_gate_chk #(
  parameter int SEL_CYCLES = `PSL_SEL_CYCLES
) (
  // Clock, reset and control pins
  input wire logic CLK,
  input wire logic SRST,
  input wire logic PWR_GOOD,
  input wire logic POWER_DOWN_N,
  input wire logic MEMCLK_FANOUT_IN,
  input wire logic REF_CLK_OUT0_I,
  // Clock outputs
  input wire logic [`PSL_MEMCLK_N-1:0] MEMCLK_FANOUT_OUT,
  input wire logic [`PSL_STRAP_N-1:0] STRAP_PIN_O,
  input wire logic [`PSL_STRAP_N-1:0] STRAP_PIN_OE_N,
  input wire logic REF_CLK_OUT0_OE_N,
  input wire logic PROC_CLK_TRUE,
  input wire logic PROC_CLK_COMP_OE_N,
  input wire logic CHIPSET_PROC_CLK_OE_N,
  input wire logic [`PSL_BUSCLK_N-1:0] BUS_CLK_OUT,
  // Latched state and bus
  input wire logic [3:0] FREQ_SELECT_STRAPS,
  input wire logic FUNCTION_STRAP,
  input wire logic STRAPS_VALID,
  input wire logic RVALID,
  input wire logic [1:0] RRESP
);
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff SRST;
  // Cycles from the power-good rise until the straps show valid; a counter
  // because the real selection window is far too long for a delay
  logic pg_seen_q;
  logic [`PSL_TMR_W-1:0] pg_cnt_q;
  always_ff @(posedge CLK) begin
    if (SRST) begin
      pg_seen_q <= 1'b0;
      pg_cnt_q <= '0;
    end else if (!pg_seen_q) begin
      pg_seen_q <= PWR_GOOD;
    end else if (!STRAPS_VALID) begin
      pg_cnt_q <= pg_cnt_q + `PSL_TMR_W'(1);
    end
  end
  // Pipeline of three stages must refill before $past is trusted
  logic [1:0] up_q;
  always_ff @(posedge CLK) begin
    if (SRST) begin
      up_q <= 2'h0;
    end else if (up_q != 2'h3) begin
      up_q <= up_q + 2'h1;
    end
  end
  ////////////////////////////////////////////////////////////////////////
  AST_MEM_COPY: assert property (up_q == 2'h3 |->
    MEMCLK_FANOUT_OUT == {`PSL_MEMCLK_N{$past(MEMCLK_FANOUT_IN, 3)
    & $past(POWER_DOWN_N, 3)}}) else $error("memory clock copy wrong");
  AST_PDN_LOW: assert property (
    up_q == 2'h3 && !$past(POWER_DOWN_N, 3) |-> !PROC_CLK_TRUE
    && BUS_CLK_OUT == 4'h0 && STRAP_PIN_O == 5'h00)
    else $error("clock not low in power down");
  AST_PDN_FLOAT: assert property (
    up_q == 2'h3 && !$past(POWER_DOWN_N, 3) |-> PROC_CLK_COMP_OE_N)
    else $error("complement clock driven in power down");
  AST_SEL_FLOAT: assert property (
    !STRAPS_VALID |-> STRAP_PIN_OE_N == 5'h1f)
    else $error("strap pin driven during selection");
  AST_SEL_QUIET: assert property (
    !STRAPS_VALID |-> BUS_CLK_OUT == 4'h0 && !PROC_CLK_TRUE
    && REF_CLK_OUT0_OE_N && CHIPSET_PROC_CLK_OE_N)
    else $error("clock active during selection");
  AST_DRV_SWITCH: assert property (
    $rose(STRAPS_VALID) |-> STRAP_PIN_OE_N == 5'h1f
    ##1 STRAP_PIN_OE_N == 5'h00) else $error("driver enable misplaced");
  AST_HOLD: assert property (
    STRAPS_VALID |=> STRAPS_VALID
    && $stable({FUNCTION_STRAP, FREQ_SELECT_STRAPS}))
    else $error("latched straps changed");
  AST_SEL_LEN: assert property (
    $rose(STRAPS_VALID) |-> pg_seen_q
    && pg_cnt_q == `PSL_TMR_W'(SEL_CYCLES + 3))
    else $error("selection length wrong");
  AST_SEL_LATE: assert property (
    !STRAPS_VALID |-> pg_cnt_q <= `PSL_TMR_W'(SEL_CYCLES + 3))
    else $error("selection window overran");
  AST_STOP: assert property (
    STRAPS_VALID && !FUNCTION_STRAP && !$past(REF_CLK_OUT0_I, 3)
    |-> !PROC_CLK_TRUE && PROC_CLK_COMP_OE_N)
    else $error("processor clock not stopped");
  AST_REF_FUNC: assert property (
    STRAPS_VALID && $past(STRAPS_VALID, 2)
    |-> REF_CLK_OUT0_OE_N == !FUNCTION_STRAP)
    else $error("shared pin function wrong");
  CVR_RUN: cover property ($rose(STRAPS_VALID));
  CVR_PDN: cover property (!POWER_DOWN_N && STRAPS_VALID);
  CVR_ERR: cover property (RVALID && RRESP == 2'b10);
endmodule
bind psl_strap_gate psl_strap_gate_chk #(.SEL_CYCLES(SEL_CYCLES)) i_chk (
  .CLK, .SRST, .PWR_GOOD, .POWER_DOWN_N, .MEMCLK_FANOUT_IN,
  .REF_CLK_OUT0_I, .MEMCLK_FANOUT_OUT, .STRAP_PIN_O, .STRAP_PIN_OE_N,
  .REF_CLK_OUT0_OE_N, .PROC_CLK_TRUE, .PROC_CLK_COMP_OE_N,
  .CHIPSET_PROC_CLK_OE_N, .BUS_CLK_OUT, .FREQ_SELECT_STRAPS,
  .FUNCTION_STRAP, .STRAPS_VALID, .RVALID, .RRESP);

// [psl_board_model.sv]
// Board strap resistors and chipset stop line on the shared pins
module psl_board_model (
  // Device pin drive
  input wire logic [4:0] pin_o,
  input wire logic [4:0] pin_oe_n,
  input wire logic ref_o,
  input wire logic ref_oe_n,
  // Board setup
  input wire logic [4:0] strap,
  input wire logic stop_n,
  // Resolved levels
  output logic [4:0] pin_i,
  output logic ref_i
);
  // A released pin sits at its strap resistor level
  always_comb begin
    for (int i = 0; i < 5; i++) begin
      pin_i[i] = pin_oe_n[i] ? strap[i] : pin_o[i];
    end
  end
  // Chipset drives the stop line only while the device floats it
  assign ref_i = ref_oe_n ? stop_n : ref_o;
endmodule

// [psl_strap_gate_bench.sv]
// Self-checking bench for the strap latch and memory clock gate
`include "psl_cfg.svh"
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin mismatches++; \
  $display("[FAIL] %0t got %h exp %h", $time, a, e); end end
module psl_strap_gate_bench;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int SEL = 16;
  typedef struct packed {logic [4:0] strap; logic spread;} psl_row_t;
  psl_row_t rows [5] = '{'{5'h1f, 1'b1}, '{5'h0c, 1'b0},
    '{5'h1a, 1'b1}, '{5'h17, 1'b0}, '{5'h09, 1'b1}};
  int mismatches = 0;
  int n_checks = 0;
  logic CLK = 1'b0;
  logic SRST, PWR_GOOD, POWER_DOWN_N, MEMCLK_FANOUT_IN;
  logic PROC_SRC, PROC_SS_SRC, BUS_SRC, BUS_SS_SRC, USB_SRC, SIO_SRC;
  logic REF_SRC, REF_CLK_OUT0_I, REF_CLK_OUT0_O, REF_CLK_OUT0_OE_N;
  logic PROC_CLK_TRUE, PROC_CLK_COMP_O, PROC_CLK_COMP_OE_N;
  logic CHIPSET_PROC_CLK_O, CHIPSET_PROC_CLK_OE_N;
  logic FUNCTION_STRAP, STRAPS_VALID, SPREAD_ACTIVE;
  logic AWVALID, AWREADY, WVALID, WREADY, BVALID, BREADY;
  logic ARVALID, ARREADY, RVALID, RREADY, stop_n;
  logic [12:0] MEMCLK_FANOUT_OUT;
  logic [4:0] STRAP_PIN_I, STRAP_PIN_O, STRAP_PIN_OE_N, strap;
  logic [3:0] BUS_CLK_OUT, FREQ_SELECT_STRAPS, AWADDR, ARADDR, WSTRB;
  logic [31:0] WDATA, RDATA, rd;
  logic [1:0] BRESP, RRESP, rs;
  logic [2:0] src_q = 3'h0;
  psl_strap_gate #(.SEL_CYCLES(SEL)) i_dut (.CLK, .SRST, .PWR_GOOD,
    .POWER_DOWN_N, .MEMCLK_FANOUT_IN, .MEMCLK_FANOUT_OUT, .PROC_SRC,
    .PROC_SS_SRC, .BUS_SRC, .BUS_SS_SRC, .USB_SRC, .SIO_SRC, .REF_SRC,
    .STRAP_PIN_I, .STRAP_PIN_O, .STRAP_PIN_OE_N, .REF_CLK_OUT0_I,
    .REF_CLK_OUT0_O, .REF_CLK_OUT0_OE_N, .PROC_CLK_TRUE, .PROC_CLK_COMP_O,
    .PROC_CLK_COMP_OE_N, .CHIPSET_PROC_CLK_O, .CHIPSET_PROC_CLK_OE_N,
    .BUS_CLK_OUT, .FREQ_SELECT_STRAPS, .FUNCTION_STRAP, .STRAPS_VALID,
    .SPREAD_ACTIVE, .AWADDR, .AWVALID, .AWREADY, .WDATA, .WSTRB, .WVALID,
    .WREADY, .BRESP, .BVALID, .BREADY, .ARADDR, .ARVALID, .ARREADY,
    .RDATA, .RRESP, .RVALID, .RREADY);
  psl_board_model i_board (.pin_o(STRAP_PIN_O), .pin_oe_n(STRAP_PIN_OE_N),
    .ref_o(REF_CLK_OUT0_O), .ref_oe_n(REF_CLK_OUT0_OE_N), .strap(strap),
    .stop_n(stop_n), .pin_i(STRAP_PIN_I), .ref_i(REF_CLK_OUT0_I));
  always #50 CLK = ~CLK;
  // Synthesiser sources toggle so gated outputs show real activity
  always @(posedge CLK) src_q <= src_q + 3'h1;
  assign {USB_SRC, PROC_SS_SRC, PROC_SRC} = src_q;
  assign {SIO_SRC, BUS_SS_SRC, BUS_SRC} = src_q;
  assign REF_SRC = src_q[0];
  ////////////////////////////////////////////////////////////////////////
  task automatic conclude();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic axi_wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge CLK);
    AWADDR <= a;
    WDATA <= d;
    AWVALID <= 1'b1;
    WVALID <= 1'b1;
    BREADY <= 1'b1;
    do begin
      @(posedge CLK);
      AWVALID <= AWVALID && !AWREADY;
      WVALID <= WVALID && !WREADY;
      BREADY <= !BVALID;
    end while (!BVALID);
    rs = BRESP;
  endtask
  task automatic axi_rd(input logic [3:0] a);
    @(posedge CLK);
    ARADDR <= a;
    ARVALID <= 1'b1;
    RREADY <= 1'b1;
    do begin
      @(posedge CLK);
      ARVALID <= ARVALID && !ARREADY;
      RREADY <= !RVALID;
    end while (!RVALID);
    rd = RDATA;
    rs = RRESP;
  endtask
  // Full power cycle: straps are only resampled this way
  task automatic power_on(input logic [4:0] s);
    SRST <= 1'b1;
    PWR_GOOD <= 1'b0;
    strap <= s;
    repeat (3) @(posedge CLK);
    SRST <= 1'b0;
    repeat (2) @(posedge CLK);
    PWR_GOOD <= 1'b1;
    repeat (SEL) @(posedge CLK);
    `CHK(STRAP_PIN_OE_N, 5'h1f)
    `CHK(STRAPS_VALID, 1'b0)
    `CHK(BUS_CLK_OUT, 4'h0)
    repeat (8) @(posedge CLK);
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    {PWR_GOOD, MEMCLK_FANOUT_IN} = 2'b00;
    {AWVALID, WVALID, BREADY, ARVALID, RREADY, AWADDR, ARADDR} = '0;
    {SRST, POWER_DOWN_N, stop_n} = 3'h7;
    WSTRB = 4'hf;
    WDATA = 32'h0;
    strap = 5'h0f;
    repeat (2) @(posedge CLK);
    SRST <= 1'b0;
    // Let one edge pass so reset is seen low before the power cycle below re-drives it
    @(posedge CLK);
    foreach (rows[i]) begin
      power_on(rows[i].strap);
      `CHK(FREQ_SELECT_STRAPS, rows[i].strap[3:0])
      `CHK(FUNCTION_STRAP, rows[i].strap[4])
      `CHK(STRAP_PIN_OE_N, 5'h00)
      `CHK(SPREAD_ACTIVE, rows[i].spread)
      `CHK(REF_CLK_OUT0_OE_N, ~rows[i].strap[4])
      `CHK(REF_CLK_OUT0_O, rows[i].strap[4] & ~REF_SRC)
      `CHK(PROC_CLK_COMP_O, ~PROC_CLK_TRUE)
      $display("row %0d done", i);
    end
    axi_wr(4'h0, 32'h0);
    `CHK(rs, `PSL_RESP_OKAY)
    repeat (3) @(posedge CLK);
    `CHK(SPREAD_ACTIVE, 1'b0)
    axi_rd(4'h4);
    `CHK(rd[7:0], 8'h29)
    axi_rd(4'h8);
    `CHK(rs, `PSL_RESP_SLVERR)
    `CHK(rd, 32'h0)
    axi_wr(4'hc, 32'h1);
    `CHK(rs, `PSL_RESP_SLVERR)
    axi_wr(4'h0, 32'h1);
    repeat (3) @(posedge CLK);
    `CHK(SPREAD_ACTIVE, 1'b1)
    $display("spread control done");
    stop_n <= 1'b0;
    repeat (4) @(posedge CLK);
    `CHK(PROC_CLK_TRUE, 1'b0)
    `CHK(PROC_CLK_COMP_OE_N, 1'b1)
    stop_n <= 1'b1;
    MEMCLK_FANOUT_IN <= 1'b1;
    repeat (4) @(posedge CLK);
    `CHK(MEMCLK_FANOUT_OUT, 13'h1fff)
    POWER_DOWN_N <= 1'b0;
    repeat (4) @(posedge CLK);
    `CHK(MEMCLK_FANOUT_OUT, 13'h0000)
    `CHK(PROC_CLK_COMP_OE_N, 1'b1)
    `CHK({BUS_CLK_OUT, STRAP_PIN_O}, 9'h000)
    `CHK({CHIPSET_PROC_CLK_O, CHIPSET_PROC_CLK_OE_N}, 2'b00)
    POWER_DOWN_N <= 1'b1;
    $display("stop and power down done");
    strap <= 5'h16;
    PWR_GOOD <= 1'b0;
    repeat (4) @(posedge CLK);
    PWR_GOOD <= 1'b1;
    repeat (SEL + 8) @(posedge CLK);
    `CHK(FREQ_SELECT_STRAPS, 4'h9)
    `CHK(STRAPS_VALID, 1'b1)
    $display("strap hold done");
    conclude();
  end
  initial begin
    repeat (6 * (SEL + 20) + 300) @(posedge CLK);
    mismatches++;
    conclude();
  end
endmodule
